// ===== wp_status.sv
// Write protection, status byte and suspend logic of an SPI serial memory
// Summary of operation
// - Suspend low freezes the serial sequence; release resumes without a new command.
// - Suspend tied high never suspends the device.
// - Status byte read-only when hardware protection active or write latch clear.
// - Otherwise a valid status write updates the protection fields.
// - Bit 0 reads 0 when ready, 1 while an internal write runs.
// - While busy only status read is accepted.
// - Bit 1 is the write latch; clear blocks status writes and array writes.
// - Write latch clears at power-up, set only by the set-latch command.
// - Protect select bits 2 and 3 are nonvolatile, factory value zero.
// - Bits 4 to 6 are not retained and read zero except during writes.
// - Selected region is read-only regardless of arm bit, pin or latch.
// - Bit 7 arms hardware protection, active with protect pin low.
// - Hardware protection locks status fields only, never the array.
// - Arm bit cannot go from 1 to 0 while protect pin is low.
// - During an internal write all status bits read 1.
// - Status write ignored unless latch set and hardware protection inactive.
// - Latch clears on clear-latch and when an accepted status or array write starts.
// - Opcode 0000 X110 sets the write latch.
`timescale 1ns/100ps
`default_nettype none
module wp_status #(
    parameter int WRITE_CYCLES = wp_status_pkg::WRITE_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       hold_n,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe_n,
    output logic            busy,
    output logic            array_wr_go,
    output logic [9:0]      array_wr_addr,
    output logic [7:0]      array_wr_data,
    output logic [7:0]      status_image
);
    // Elaboration check on the write cycle length
    if (WRITE_CYCLES < 1)
    begin : g_bad_write_cycles
        $error("WRITE_CYCLES must be at least 1");
    end

    // Protected region test
    function automatic logic in_region(input logic [1:0] sel, input logic [9:0] a);
        in_region = (sel == 2'h3) ||
                    (sel == 2'h2 && a >= wp_status_pkg::HALF_BASE) ||
                    (sel == 2'h1 && a >= wp_status_pkg::QUARTER_BASE);
    endfunction

    // ------------------------------------------------------------------
    // Link domain: shifter on sck, gated by suspend
    // ------------------------------------------------------------------
    logic        hold_live;
    logic [31:0] sh_q, sh_d;
    logic [5:0]  cnt_q, cnt_d;
    logic        fresh_q = 1'b1;
    logic        fresh_d;
    logic [7:0]  so_byte_q, so_byte_d;
    logic        so_q, so_d;
    logic        so_oe_n_q, so_oe_n_d;
    logic        rd_stat_q, rd_stat_d;
    logic [7:0]  stat_sync1_q, stat_sync2_q;

    // Suspend is sampled in the link domain; master keeps it stable over edges
    assign hold_live = hold_n;

    // Bit shift, frozen while suspended; first edge of a frame restarts the count
    always_comb
    begin
        sh_d    = sh_q;
        cnt_d   = cnt_q;
        fresh_d = fresh_q;
        if (hold_live)
        begin
            fresh_d = 1'b0;
            if (fresh_q)
            begin
                sh_d  = {31'h0000_0000, si};
                cnt_d = 6'h01;
            end
            else if (cnt_q != wp_status_pkg::BITS_DAT)
            begin
                sh_d  = {sh_q[30:0], si};
                cnt_d = cnt_q + 6'h01;
            end
        end
    end

    // Shifter keeps the last frame while chip select is high, so the core can copy it
    always_ff @(posedge sck)
    begin
        sh_q  <= sh_d;
        cnt_q <= cnt_d;
    end

    // Frame start marker, armed whenever chip select is high
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
            fresh_q <= 1'b1;
        else
            fresh_q <= fresh_d;
    end

    // Status image brought into the link domain; it only moves at frame end or when busy ends,
    // and a read that straddles the end of busy may show a mixed byte
    always_ff @(posedge sck)
    begin
        stat_sync1_q <= status_image;
        stat_sync2_q <= stat_sync1_q;
    end

    // Output byte shifts on falling edge; pin released at the first falling edge while suspended
    always_comb
    begin
        so_byte_d = so_byte_q;
        rd_stat_d = rd_stat_q;
        so_d      = so_q;
        so_oe_n_d = 1'b1;
        if (hold_live)
        begin
            if (cnt_q == wp_status_pkg::BITS_OP)
            begin
                so_byte_d = stat_sync2_q;
                so_d      = stat_sync2_q[7];
                rd_stat_d = (sh_q[7:0] & wp_status_pkg::OP_MASK) == wp_status_pkg::OP_RD_STAT;
            end
            else
            begin
                so_byte_d = {so_byte_q[6:0], 1'b0};
                so_d      = so_byte_q[6];
            end
            so_oe_n_d = !rd_stat_d;
        end
    end

    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            so_byte_q <= 8'h00;
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
            rd_stat_q <= 1'b0;
        end
        else
        begin
            so_byte_q <= so_byte_d;
            so_q      <= so_d;
            so_oe_n_q <= so_oe_n_d;
            rd_stat_q <= rd_stat_d;
        end
    end

    // ------------------------------------------------------------------
    // Core domain: frame end capture and status logic
    // ------------------------------------------------------------------
    logic [2:0]  cs_sync_q;
    logic        cs_lvl_q, cs_lvl_d;
    logic        cs_rise;
    logic        frame_q;
    logic [31:0] cap_q, cap_d;
    logic [5:0]  cap_cnt_q, cap_cnt_d;
    logic        wel_q, wel_d;
    logic [1:0]  sel_q = wp_status_pkg::SEL_FACTORY;
    logic [1:0]  sel_d;
    logic        arm_q = 1'b0;
    logic        arm_d;
    logic [2:0]  wp_sync_q;
    logic        wp_lvl_q, wp_lvl_d;
    logic        wp_low;
    logic [31:0] tmr_q, tmr_d;
    logic        busy_q, busy_d;
    logic        go_q, go_d;
    logic [9:0]  adr_q, adr_d;
    logic [7:0]  dat_q, dat_d;
    logic [7:0]  img_d, img_q;
    logic [7:0]  op;
    logic        hw_prot;

    // Pins through three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cs_sync_q <= 3'h7;
            wp_sync_q <= 3'h7;
            cs_lvl_q  <= 1'b1;
            wp_lvl_q  <= 1'b1;
            frame_q   <= 1'b0;
        end
        else
        begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
            wp_sync_q <= {wp_sync_q[1:0], wp_n};
            cs_lvl_q  <= cs_lvl_d;
            wp_lvl_q  <= wp_lvl_d;
            frame_q   <= cs_rise;
        end
        // Shifter is stable while chip select is high, sampled at frame end
        cap_q     <= cap_d;
        cap_cnt_q <= cap_cnt_d;
    end

    // Filtered pin levels; idle chip select level after reset avoids a false frame end
    assign cs_lvl_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_lvl_q;
    assign wp_lvl_d = (wp_sync_q[1] == wp_sync_q[2]) ? wp_sync_q[2] : wp_lvl_q;
    assign cs_rise  = cs_sync_q[1] && cs_sync_q[2] && !cs_lvl_q;
    assign wp_low   = !wp_lvl_q;
    assign hw_prot  = arm_q && wp_low;
    assign op       = cap_q[31:24] & wp_status_pkg::OP_MASK;

    // Snapshot of the link shifter taken as chip select rises
    always_comb
    begin
        cap_d     = cap_q;
        cap_cnt_d = cap_cnt_q;
        if (cs_rise)
        begin
            cap_cnt_d = cnt_q;
            cap_d     = sh_q << (wp_status_pkg::BITS_DAT - cnt_q);
        end
    end

    // Command execution at frame end
    always_comb
    begin
        wel_d = wel_q;
        sel_d = sel_q;
        arm_d = arm_q;
        busy_d = busy_q;
        tmr_d = tmr_q;
        go_d  = 1'b0;
        adr_d = adr_q;
        dat_d = dat_q;
        if (busy_q)
        begin
            tmr_d = tmr_q - 32'd1;
            if (tmr_q == 32'd1)
                busy_d = 1'b0;
        end
        else if (frame_q)
        begin
            if (op == wp_status_pkg::OP_SET_WL && cap_cnt_q == wp_status_pkg::BITS_OP)
                wel_d = 1'b1;
            else if (op == wp_status_pkg::OP_CLR_WL && cap_cnt_q == wp_status_pkg::BITS_OP)
                wel_d = 1'b0;
            else if (op == wp_status_pkg::OP_WR_STAT && cap_cnt_q == wp_status_pkg::BITS_STAT)
            begin
                if (wel_q && !hw_prot)
                begin
                    sel_d  = {cap_q[16 + wp_status_pkg::SEL_HI], cap_q[16 + wp_status_pkg::SEL_LO]};
                    if (!(arm_q && !cap_q[16 + wp_status_pkg::ARM_BIT] && wp_low))
                        arm_d = cap_q[16 + wp_status_pkg::ARM_BIT];
                    wel_d  = 1'b0;
                    busy_d = 1'b1;
                    tmr_d  = 32'(WRITE_CYCLES);
                end
            end
            else if (op == wp_status_pkg::OP_WR_ARR && cap_cnt_q == wp_status_pkg::BITS_DAT)
            begin
                // Array write needs latch and an address outside the selected region; hardware protection is ignored
                if (wel_q && !in_region(sel_q, cap_q[17:8]))
                begin
                    go_d   = 1'b1;
                    adr_d  = cap_q[17:8];
                    dat_d  = cap_q[7:0];
                    wel_d  = 1'b0;
                    busy_d = 1'b1;
                    tmr_d  = 32'(WRITE_CYCLES);
                end
            end
        end
        // Status view; bits 4..6 not retained, all ones while busy
        img_d = 8'h00;
        img_d[wp_status_pkg::WEL_BIT] = wel_d;
        img_d[wp_status_pkg::SEL_LO]  = sel_d[0];
        img_d[wp_status_pkg::SEL_HI]  = sel_d[1];
        img_d[wp_status_pkg::ARM_BIT] = arm_d;
        img_d[wp_status_pkg::BUSY_BIT] = busy_d;
        if (busy_d)
            img_d = wp_status_pkg::BUSY_IMAGE;
    end

    // Register the volatile status state; select and arm bits are registered below
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wel_q  <= 1'b0;
            busy_q <= 1'b0;
            tmr_q  <= 32'd0;
            go_q   <= 1'b0;
            adr_q  <= 10'h000;
            dat_q  <= 8'h00;
            img_q  <= 8'h00;
        end
        else
        begin
            wel_q  <= wel_d;
            busy_q <= busy_d;
            tmr_q  <= tmr_d;
            go_q   <= go_d;
            adr_q  <= adr_d;
            dat_q  <= dat_d;
            img_q  <= img_d;
        end
    end

    // Nonvolatile fields keep their value across reset; factory value at start
    always_ff @(posedge core_clk)
    begin
        sel_q <= sel_d;
        arm_q <= arm_d;
    end

    assign so            = so_q;
    assign so_oe_n       = so_oe_n_q;
    assign busy          = busy_q;
    assign array_wr_go   = go_q;
    assign array_wr_addr = adr_q;
    assign array_wr_data = dat_q;
    assign status_image  = img_q;
endmodule
`default_nettype wire

// ===== wp_status_pkg.sv
// Constants for the write-protect and status block of the serial memory
package wp_status_pkg;
    // Status byte bit positions
    localparam int BUSY_BIT  = 0;
    localparam int WEL_BIT   = 1;
    localparam int SEL_LO    = 2;
    localparam int SEL_HI    = 3;
    localparam int ARM_BIT   = 7;
    // Opcodes, don't-care bit 3 masked off
    localparam logic [7:0] OP_MASK    = 8'hF7;
    localparam logic [7:0] OP_SET_WL  = 8'h06;
    localparam logic [7:0] OP_CLR_WL  = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_WR_ARR  = 8'h02;
    // Protected region start addresses
    localparam logic [9:0] QUARTER_BASE = 10'h300;
    localparam logic [9:0] HALF_BASE    = 10'h200;
    // Busy status image and factory value of the protect bits
    localparam logic [7:0] BUSY_IMAGE = 8'hFF;
    localparam logic [1:0] SEL_FACTORY = 2'h0;
    // Bit count helpers
    localparam logic [5:0] BITS_OP   = 6'h08;
    localparam logic [5:0] BITS_ADR  = 6'h18;
    localparam logic [5:0] BITS_STAT = 6'h10;
    localparam logic [5:0] BITS_DAT  = 6'h20;
    // Internal write cycle length
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_MHZ       = 10;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
endpackage

// ===== wp_status_monitor.sv
// Assertion checker for the write-protect and status block
`timescale 1ns/100ps
`default_nettype none
module wp_status_monitor #(
    parameter int WRITE_CYCLES = wp_status_pkg::WRITE_CYCLES
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic       hold_n,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe_n,
    input wire logic       busy,
    input wire logic       array_wr_go,
    input wire logic [9:0] array_wr_addr,
    input wire logic [7:0] array_wr_data,
    input wire logic [7:0] status_image
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [1:0] sel_q;
    // Protect selection as it stood one cycle earlier
    always_ff @(posedge core_clk) sel_q <= status_image[3:2];
    property p_busy_image; busy && $past(busy, 2) |-> status_image == 8'hFF; endproperty
    a_busy_image: assert property (p_busy_image) else $error("status not all ones");
    property p_ready; !busy && !$past(busy, 3) |-> status_image[6:4] == 3'h0 && !status_image[0]; endproperty
    a_ready: assert property (p_ready) else $error("idle status bits set");
    property p_go_busy; array_wr_go |=> !array_wr_go ##[0:2] busy; endproperty
    a_go_busy: assert property (p_go_busy) else $error("write did not go busy");
    property p_go_latch; array_wr_go |-> $past(status_image[1]); endproperty
    a_go_latch: assert property (p_go_latch) else $error("write without latch");
    property p_go_region; array_wr_go |-> sel_q == 2'h0 || (sel_q == 2'h1 && array_wr_addr < 10'h300)
        || (sel_q == 2'h2 && array_wr_addr < 10'h200); endproperty
    a_go_region: assert property (p_go_region) else $error("protected write");
    property p_latch_clr; $fell(busy) |-> ##[0:3] !status_image[1]; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept");
    property p_arm_hold; !busy && !$past(busy, 3) && !wp_n && status_image[7] |=> status_image[7]; endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("arm bit dropped");
    property p_busy_len; $rose(busy) |-> busy [*8] ##[1:300] !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    c_go: cover property (array_wr_go);
    c_done: cover property ($fell(busy));
    c_armed: cover property (status_image[7] && !wp_n && !busy);
endmodule
bind wp_status wp_status_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_wp_status_monitor (
    .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .busy(busy), .array_wr_go(array_wr_go),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data), .status_image(status_image));
`default_nettype wire

// ===== spi_master_model.sv
// Behavioural serial bus master that frames commands for the block
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    output logic     hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    // ----------------------------------------------------------------
    // Frame driver
    // ----------------------------------------------------------------
    logic [31:0] rx_q;
    initial {sck, cs_n, si, hold_n} = 4'h7;
    // Shift n bits MSB first, optionally suspending in mid-frame
    task automatic xfer(input int n, input logic [31:0] tx, input bit pause);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = tx[i];
            #16 sck = 1'b1;
            rx_q = {rx_q[30:0], so_oe_n ? 1'b1 : so};
            #16 sck = 1'b0;
            if (pause && i == n - 4)
            begin
                #8 hold_n = 1'b0;
                repeat (4) #16 {sck, si} = {~sck, ~si};
                #16 hold_n = 1'b1;
            end
        end
        #16 cs_n = 1'b1;
        si = ~si;
    endtask
endmodule
`default_nettype wire

// ===== wp_status_tb.sv
// Self-checking bench for the write-protect and status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module wp_status_tb;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic       wp_n     = 1'b1;
    logic       sck, cs_n, si, hold_n, so, so_oe_n, busy, array_wr_go, go_seen;
    logic [9:0] array_wr_addr, go_a;
    logic [7:0] array_wr_data, status_image, go_d, v;
    int         fails, total_checks, cyc;
    int         lim[4] = '{1024, 768, 512, 0};
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    always #50 core_clk = ~core_clk;
    wp_status #(.WRITE_CYCLES(40)) u_wp_status (.core_clk(core_clk), .rst(rst), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
        .busy(busy), .array_wr_go(array_wr_go), .array_wr_addr(array_wr_addr),
        .array_wr_data(array_wr_data), .status_image(status_image));
    spi_master_model u_spi_master_model (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so(so), .so_oe_n(so_oe_n));
    // Catch write pulses and cut a hang short
    always @(posedge core_clk)
    begin
        cyc++;
        if (array_wr_go === 1'b1) {go_seen, go_a, go_d} <= {1'b1, array_wr_addr, array_wr_data};
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmd(input int n, input logic [31:0] tx, input bit pause);
        u_spi_master_model.xfer(n, tx, pause);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic ready();
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge core_clk);
        `CHK("ready", 1'b0, busy)
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rd();
        cmd(16, 32'h0500, 0);
        v = u_spi_master_model.rx_q[7:0];
    endtask
    task automatic wr_stat(input logic [7:0] d);
        cmd(8, 32'h06, 0);
        cmd(16, {16'h0, 8'h01, d}, 0);
        ready();
    endtask
    task automatic arr(input logic [9:0] a, input logic [7:0] d, input logic ex);
        cmd(8, 32'h06, 0);
        go_seen = 1'b0;
        cmd(32, {8'h02, 6'h0, a, d}, 0);
        `CHK("go", ex, go_seen)
        if (ex) `CHK("addr", {a, d}, {go_a, go_d})
        ready();
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd();
        `CHK("reset status", 8'h00, v)
        cmd(16, 32'h0184, 0);
        rd();
        `CHK("unlatched write", 8'h00, v)
        cmd(8, 32'h0E, 0);
        rd();
        `CHK("latch set", 8'h02, v)
        cmd(8, 32'h04, 0);
        rd();
        `CHK("latch cleared", 8'h00, v)
        cmd(8, 32'h06, 1);
        rd();
        `CHK("suspended frame", 8'h02, v)
        cmd(16, 32'h0174, 0);
        rd();
        `CHK("busy image", 8'hFF, v)
        cmd(8, 32'h06, 0);
        ready();
        rd();
        rd();
        `CHK("after write", 8'h04, v)
        for (int s = 0; s < 4; s++)
        begin
            wr_stat({4'h0, s[1:0], 2'h0});
            for (int j = 0; j < 3; j++)
                arr(10'(1023 - 256 * j), 8'(j + 90), (1023 - 256 * j) < lim[s]);
        end
        wr_stat(8'h84);
        wp_n <= 1'b0;
        wr_stat(8'h00);
        rd();
        `CHK("armed fields", 8'h86, v)
        arr(10'h0FF, 8'h3C, 1'b1);
        wp_n <= 1'b1;
        wr_stat(8'h00);
        rd();
        `CHK("disarmed", 8'h00, v)
        go_seen = 1'b0;
        cmd(32, {8'h02, 6'h00, 10'h010, 8'h55}, 0);
        `CHK("unlatched array", 1'b0, go_seen)
        stop_test();
    end
endmodule
`default_nettype wire
